// ==== common/sgwl_defines.svh ====
`ifndef SGWL_DEFINES_SVH
`define SGWL_DEFINES_SVH

// Serial gain word width
`define SGWL_WORD_BITS 8
// Gain code after reset
`define SGWL_GAIN_RST 8'h00
// Number of gain levels selectable by the code
`define SGWL_GAIN_LEVELS 256

`endif

// ==== common/sgwl_pkg.sv ====
`default_nettype none
`include "sgwl_defines.svh"

package sgwl_pkg;

    typedef logic [`SGWL_WORD_BITS-1:0] sgwl_word_t;

    typedef enum logic {
        SGWL_AMP_REVERSE = 1'b0,
        SGWL_AMP_FORWARD = 1'b1
    } sgwl_amp_mode_t;

endpackage : sgwl_pkg

`default_nettype wire

// ==== rtl/sgwl_gain_loader.sv ====
`default_nettype none
`include "sgwl_defines.svh"

// Notes on behaviour
// - Eight-bit gain word, most significant bit first
// - Rising edge captures master, falling moves slave
// - Strobe rise latches word, stops shifting
// - Strobe fall holds latch, enables shifting
// - Power-down low selects reverse, high forward
// - Latched code is unsigned gain, 256 levels
module sgwl_gain_loader
    import sgwl_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic link_clk,
    input wire logic serial_gain_in,
    input wire logic load_strobe_n,
    input wire logic amp_on_n_ctrl,
    output logic [`SGWL_WORD_BITS-1:0] gain_code,
    output logic gain_update,
    output logic fwd_amp_en,
    output logic rev_amp_en
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: master-slave shift register

    logic master_reg;
    logic master_next;
    logic shift_en_reg;
    logic shift_en_next;
    sgwl_word_t slave_reg;
    sgwl_word_t slave_next;

    // Bits sampled on the link clock itself, no synchroniser needed
    always_comb begin
        shift_en_next = ~load_strobe_n;
        master_next = master_reg;
        if (~load_strobe_n) begin
            master_next = serial_gain_in;
        end
    end

    always_ff @(posedge link_clk) begin
        master_reg <= master_next;
        shift_en_reg <= shift_en_next;
    end

    // Older bits fall off the top, so only the last eight remain
    always_comb begin
        slave_next = slave_reg;
        if (shift_en_reg) begin
            slave_next = {slave_reg[`SGWL_WORD_BITS-2:0], master_reg};
        end
    end

    always_ff @(negedge link_clk) begin
        slave_reg <= slave_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: synchronisers

    logic strobe_s1_reg;
    logic strobe_s2_reg;
    logic strobe_s3_reg;
    logic pwr_s1_reg;
    logic pwr_s2_reg;
    logic strobe_s1_next;
    logic strobe_s2_next;
    logic strobe_s3_next;
    logic pwr_s1_next;
    logic pwr_s2_next;

    always_comb begin
        strobe_s1_next = load_strobe_n;
        strobe_s2_next = strobe_s1_reg;
        strobe_s3_next = strobe_s2_reg;
        pwr_s1_next = amp_on_n_ctrl;
        pwr_s2_next = pwr_s1_reg;
        if (sys_rst) begin
            strobe_s1_next = 1'b1;
            strobe_s2_next = 1'b1;
            strobe_s3_next = 1'b1;
            pwr_s1_next = 1'b0;
            pwr_s2_next = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        strobe_s1_reg <= strobe_s1_next;
        strobe_s2_reg <= strobe_s2_next;
        strobe_s3_reg <= strobe_s3_next;
        pwr_s1_reg <= pwr_s1_next;
        pwr_s2_reg <= pwr_s2_next;
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: gain latch and amplifier select

    sgwl_word_t gain_reg;
    sgwl_word_t gain_next;
    logic update_reg;
    logic update_next;
    sgwl_amp_mode_t mode_next;
    logic strobe_rise;

    // Shift word is frozen while the strobe is high, so sampling it here is safe
    assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;

    always_comb begin
        gain_next = gain_reg;
        update_next = 1'b0;
        if (strobe_rise) begin
            gain_next = slave_reg;
            update_next = 1'b1;
        end
        mode_next = pwr_s2_reg ? SGWL_AMP_FORWARD : SGWL_AMP_REVERSE;
        if (sys_rst) begin
            gain_next = `SGWL_GAIN_RST;
            update_next = 1'b0;
            mode_next = SGWL_AMP_REVERSE;
        end
    end

    always_ff @(posedge core_clk) begin
        gain_reg <= gain_next;
        update_reg <= update_next;
    end

    logic fwd_reg;
    logic rev_reg;
    logic fwd_next;
    logic rev_next;

    always_comb begin
        fwd_next = (mode_next == SGWL_AMP_FORWARD);
        rev_next = (mode_next == SGWL_AMP_REVERSE);
    end

    always_ff @(posedge core_clk) begin
        fwd_reg <= fwd_next;
        rev_reg <= rev_next;
    end

    assign gain_code = gain_reg;
    assign gain_update = update_reg;
    assign fwd_amp_en = fwd_reg;
    assign rev_amp_en = rev_reg;

endmodule : sgwl_gain_loader

`default_nettype wire

// ==== test/sgwl_host.sv ====
`default_nettype none
module sgwl_host(
    input wire logic core_clk,
    output logic link_clk = 1'b0,
    output logic serial_gain_in = 1'b0,
    output logic load_strobe_n = 1'b1
);
    timeunit 1ns;
    timeprecision 1ps;
    task send(input logic [15:0] w, input int n);
        @(posedge core_clk) load_strobe_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            serial_gain_in = w[i];
            #3 link_clk = 1'b1;
            #3 link_clk = 1'b0;
        end
        // Released data line shows the inverse
        serial_gain_in = !w[0];
        @(posedge core_clk) load_strobe_n <= 1'b1;
    endtask : send
endmodule : sgwl_host
`default_nettype wire

// ==== test/sgwl_sva.sv ====
`default_nettype none
module sgwl_sva(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic load_strobe_n,
    input wire logic amp_on_n_ctrl,
    input wire logic [7:0] gain_code,
    input wire logic gain_update,
    input wire logic fwd_amp_en,
    input wire logic rev_amp_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    sequence s_apply; ##[3:4] gain_update ##1 !gain_update; endsequence
    AST_APPLY: assert property ($rose(load_strobe_n) |-> s_apply) else $error("no apply");
    AST_HOLD: assert property (!$stable(gain_code) |-> gain_update) else $error("code moved");
    AST_STROBE: assert property (gain_update |-> load_strobe_n) else $error("apply while low");
    AST_EXCL: assert property (fwd_amp_en != rev_amp_en) else $error("amp overlap");
    AST_MODE: assert property (!$past(sys_rst, 3) |-> fwd_amp_en == $past(amp_on_n_ctrl, 3)) else $error("amp");
    AST_PULSE: assert property (gain_update |=> !gain_update) else $error("apply pulse too long");
endmodule : sgwl_sva
bind sgwl_gain_loader sgwl_sva u_sva(.*);
`default_nettype wire

// ==== test/tb.sv ====
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0;
    logic sys_rst = 1;
    logic amp_on_n_ctrl = 0;
    logic link_clk, serial_gain_in, load_strobe_n, gain_update, fwd_amp_en, rev_amp_en;
    logic [7:0] gain_code;
    int miscompares = 0;
    int checks = 0;
    always #25 core_clk = ~core_clk;
    sgwl_host host(
        .core_clk(core_clk),
        .link_clk(link_clk),
        .serial_gain_in(serial_gain_in),
        .load_strobe_n(load_strobe_n)
    );
    sgwl_gain_loader DUT(
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .link_clk(link_clk),
        .serial_gain_in(serial_gain_in),
        .load_strobe_n(load_strobe_n),
        .amp_on_n_ctrl(amp_on_n_ctrl),
        .gain_code(gain_code),
        .gain_update(gain_update),
        .fwd_amp_en(fwd_amp_en),
        .rev_amp_en(rev_amp_en)
    );
    task chk(input string s, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task conclude;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    task load(input logic [15:0] w, input int n, input logic [7:0] e);
        int k;
        host.send(w, n);
        for (k = 0; k < 8 && gain_update !== 1'b1; k++)
            @(negedge core_clk);
        if (k == 8) begin
            miscompares++;
            $display("BAD gain_update exp 1 got 0");
            conclude();
        end
        chk("gain_code", e, gain_code);
        @(negedge core_clk);
    endtask : load
    task amp(input logic v);
        @(posedge core_clk) amp_on_n_ctrl <= v;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        chk("amp_en", {6'h00, v, !v}, {6'h00, fwd_amp_en, rev_amp_en});
    endtask : amp
    initial begin
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        chk("reset_code", 8'h00, gain_code);
        chk("reset_amp", 8'h01, {5'h00, gain_update, fwd_amp_en, rev_amp_en});
        @(posedge core_clk);
        sys_rst <= 1'b0;
        load(16'h00A5, 8, 8'hA5);
        load(16'h003C, 8, 8'h3C);
        load(16'h010F, 9, 8'h0F);
        load(16'h000A, 4, 8'hFA);
        load(16'h00FF, 8, 8'hFF);
        load(16'h0000, 8, 8'h00);
        amp(1'b1);
        amp(1'b0);
        conclude();
    end
endmodule : tb
`default_nettype wire
